// File: mic_core_model.sv
// core model: program counter, one-deep return stack, return instruction
`timescale 1ns/100ps
module mic_core_model
    import mic_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic vectorLoad,
    input wire logic [12:0] vectorAddress,
    input wire logic stackPush,
    input wire logic [12:0] pushAddress,
    input wire logic doReturn,
    output logic returnFromIrq,
    output logic [12:0] pc,
    output int entries
);
    logic [12:0] stackTop; // one level: the bench never nests service routines
    ////////////////////////////////////////////////////////////////////////////
    // pc stands still outside service so the pushed address is predictable
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pc <= 13'h0123;
            stackTop <= 13'h0000;
            entries <= 0;
            returnFromIrq <= 1'b0;
        end else begin
            returnFromIrq <= doReturn;
            if (stackPush) begin
                stackTop <= pushAddress;
            end
            if (vectorLoad) begin
                pc <= vectorAddress;
                entries <= entries + 1;
            end else if (returnFromIrq) begin
                pc <= stackTop;
            end
        end
    end
    // flag clearing before return is left to the bench's register writes
endmodule : mic_core_model

// File: mic_interrupt_controller.sv
// interrupt controller: flag latching, masking, vectored request to the core
//
// Summary of operation
// - eleven sources: pin, timer, change, eight peripherals
// - global enable gates every request to core
// - every reset clears the global enable
// - return instruction sets the global enable
// - entry clears enable, pushes return, vectors 0004h
// - external event latency three or four cycles
// - flags set regardless of any enable bit
// - clearing global enable defers, never loses, requests
// - pin interrupt on selected edge sets flag
// - enabled pin edge wakes from sleep
// - timer rollover FFh to 00h sets flag
// - selected port pin change sets change flag
// - change at Q2 port read may be missed
// - pin flag may be set in Q4 or Q1
// - only the return address is saved on entry
// - core control register layout, reset zero
// - peripheral flag and enable layout, reset zero
// - enabled source wakes sleep whatever global enable
`timescale 1ns/100ps
module mic_interrupt_controller
    import mic_pkg::*;
#(
    parameter int PC_WIDTH = 13,  // program counter width
    parameter int PORT_WIDTH = 6  // port pins watched for change
) (
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regReadData,
    // event inputs
    input wire logic extPin,  // external interrupt pin, asynchronous
    input wire logic [PORT_WIDTH-1:0] portPins,  // port pins, asynchronous
    input wire logic portRead,  // core reads the port this cycle
    input wire logic [7:0] timer0Count,  // timer count, same clock
    input wire logic [7:0] periphEvent,  // one-cycle peripheral pulses, flag order
    // core handshake
    input wire logic returnFromIrq,  // return instruction executes
    input wire logic clearGlobalEnable,  // an instruction clears the global enable
    input wire logic sleeping,  // core is asleep
    input wire logic [PC_WIDTH-1:0] returnAddress,  // address to resume at
    output logic irqRequest,  // masked request level
    output logic vectorLoad,  // one-cycle pulse: load vector and push
    output logic [PC_WIDTH-1:0] vectorAddress,
    output logic stackPush,  // one-cycle pulse with the return address
    output logic [PC_WIDTH-1:0] pushAddress,
    output logic wakeUp,  // wake the core from sleep
    output logic [1:0] phase  // instruction cycle subdivision
);

    // entry machine: idle, one wait instruction cycle, then a one-clock enter
    typedef enum {IDLE, WAIT, ENTER} mic_entry_type;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] coreCtrl;  // core_interrupt_control
    logic [7:0] periphEnables;  // peripheral_interrupt_enables
    logic [7:0] periphFlags;  // peripheral_interrupt_flags
    logic extEdgeSelect;  // 1 rising, 0 falling
    logic [PORT_WIDTH-1:0] pinSelect;  // port_change_pin_select
    mic_entry_type entryState;
    logic [7:0] prevTimer;  // last timer value for rollover detect
    logic anyEnabled;  // enabled flag present, before global gate
    logic next_request;

    // true when the register address matches this target; the write strobe is checked by the caller
    function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
        hit = (a == target);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, change counts once last two agree
    logic [2:0] extSync;
    logic extStable;  // filtered pin level
    logic [PORT_WIDTH-1:0] portSync [3];
    logic [PORT_WIDTH-1:0] portStable;  // filtered port level
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            extSync <= 3'h0;
            portSync <= '{default: '0};
        end else begin
            extSync <= {extSync[1:0], extPin};
            portSync[0] <= portPins;
            portSync[1] <= portSync[0];
            portSync[2] <= portSync[1];
        end
    end

    // filtered levels only follow when stages two and three agree
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            extStable <= 1'b0;
            portStable <= '0;
        end else begin
            if (extSync[1] == extSync[2]) begin
                extStable <= extSync[2];
            end
            for (int i = 0; i < PORT_WIDTH; i++) begin
                if (portSync[1][i] == portSync[2][i]) begin
                    portStable[i] <= portSync[2][i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // phase counter Q1..Q4
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase <= MIC_PHASE_Q1;
        end else begin
            // free running: wraps from Q4 back to Q1 with no compare
            phase <= phase + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event detection
    logic extEdge;
    logic timerRoll;
    logic portChange;
    logic [PORT_WIDTH-1:0] portLast;  // value at last port read
    logic pinWindow;
    logic prevExt;
    assign pinWindow = (phase == MIC_PHASE_Q4) || (phase == MIC_PHASE_Q1);
    // edge is held until the Q4/Q1 window so none is dropped
    logic extPending;
    assign extEdge = (extStable != prevExt) && (extStable == extEdgeSelect);
    assign timerRoll = (prevTimer == MIC_TIMER_MAX) && (timer0Count == MIC_TIMER_ZERO);
    // a mismatch against the latch of the last read marks a change;
    // a read at Q2 reloads the latch and can swallow a coincident change
    assign portChange = |((portStable ^ portLast) & pinSelect);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prevExt <= 1'b0;
            prevTimer <= MIC_TIMER_ZERO;
            portLast <= '0;
            extPending <= 1'b0;
        end else begin
            prevExt <= extStable;
            // the timer runs on this clock, so it needs no synchroniser
            prevTimer <= timer0Count;
            if (portRead && phase == MIC_PHASE_Q2) begin
                portLast <= portStable;
            end
            if (extEdge) begin
                extPending <= 1'b1;
            end else if (pinWindow) begin
                extPending <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core control register: enables by software, flags set by hardware
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            coreCtrl <= MIC_RESET_REG;
        end else begin
            if (hit(regAddr, MIC_ADDR_CORE_CTRL) && regWrite) begin
                coreCtrl <= regWriteData;
            end
            if (clearGlobalEnable || entryState == ENTER) begin
                coreCtrl[MIC_BIT_GLOBAL_EN] <= 1'b0;
            end
            if (returnFromIrq) begin
                coreCtrl[MIC_BIT_GLOBAL_EN] <= 1'b1;
            end
            // set wins over a software clear in the same cycle
            if (timerRoll) begin
                coreCtrl[MIC_BIT_TIMER_FLAG] <= 1'b1;
            end
            if ((extEdge || extPending) && pinWindow) begin
                coreCtrl[MIC_BIT_PIN_FLAG] <= 1'b1;
            end
            if (portChange && !(portRead && phase == MIC_PHASE_Q2)) begin
                coreCtrl[MIC_BIT_CHANGE_FLAG] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // peripheral enables and flags
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            periphEnables <= MIC_RESET_REG;
            periphFlags <= MIC_RESET_REG;
            extEdgeSelect <= 1'b0;
            pinSelect <= '0;
        end else begin
            if (hit(regAddr, MIC_ADDR_PERIPH_EN) && regWrite) begin
                periphEnables <= regWriteData;
            end
            // a new edge select alone never makes an edge: only the pin does
            if (hit(regAddr, MIC_ADDR_EDGE_SEL) && regWrite) begin
                extEdgeSelect <= regWriteData[0];
            end
            if (hit(regAddr, MIC_ADDR_PIN_SELECT) && regWrite) begin
                pinSelect <= regWriteData[PORT_WIDTH-1:0];
            end
            // events or into the written value so a set is never lost
            if (hit(regAddr, MIC_ADDR_PERIPH_FLAGS) && regWrite) begin
                periphFlags <= regWriteData | periphEvent;
            end else begin
                periphFlags <= periphFlags | periphEvent;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request combining
    always_comb begin
        anyEnabled = (coreCtrl[MIC_BIT_TIMER_EN] && coreCtrl[MIC_BIT_TIMER_FLAG])
            || (coreCtrl[MIC_BIT_PIN_EN] && coreCtrl[MIC_BIT_PIN_FLAG])
            || (coreCtrl[MIC_BIT_CHANGE_EN] && coreCtrl[MIC_BIT_CHANGE_FLAG])
            || (coreCtrl[MIC_BIT_PERIPH_EN] && |(periphFlags & periphEnables));
        // flags are never cleared here: a left-set flag requests again
        next_request = coreCtrl[MIC_BIT_GLOBAL_EN] && anyEnabled
            && !clearGlobalEnable;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irqRequest <= 1'b0;
            wakeUp <= 1'b0;
        end else begin
            // registered, so the core sees the request one clock late
            irqRequest <= next_request;
            // wake ignores the global enable
            wakeUp <= sleeping && anyEnabled;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // entry sequence, stepped at Q4 each instruction cycle; enter leaves on the next clock
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            entryState <= IDLE;
        end else if (phase == MIC_PHASE_Q4) begin
            unique case (entryState)
                // a sleeping core wakes first; entry waits until it runs
                IDLE: if (irqRequest && !sleeping) entryState <= WAIT;
                WAIT: entryState <= ENTER;
                ENTER: entryState <= IDLE;
            endcase
        end else if (entryState == ENTER) begin
            entryState <= IDLE;  // enter lasts one clock
        end
    end

    // vector load and push of the return address only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            vectorLoad <= 1'b0;
            stackPush <= 1'b0;
            vectorAddress <= '0;
            pushAddress <= '0;
        end else begin
            vectorLoad <= (entryState == ENTER);
            stackPush <= (entryState == ENTER);
            // constant after the first clock, kept a flop so the output is registered
            vectorAddress <= PC_WIDTH'(MIC_VECTOR);
            if (entryState == ENTER) begin
                pushAddress <= returnAddress;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: data one cycle after strobe, unmapped reads zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            regReadData <= 8'h00;
        end else if (regRead) begin
            unique case (regAddr)
                MIC_ADDR_CORE_CTRL: regReadData <= coreCtrl;
                MIC_ADDR_PERIPH_EN: regReadData <= periphEnables;
                MIC_ADDR_PERIPH_FLAGS: regReadData <= periphFlags;
                MIC_ADDR_EDGE_SEL: regReadData <= {7'h00, extEdgeSelect};
                MIC_ADDR_PIN_SELECT: regReadData <= 8'(pinSelect);
                // status is read only: a write to its place is ignored
                MIC_ADDR_STATUS: regReadData <= {6'h00, wakeUp, irqRequest};
                default: regReadData <= 8'h00;
            endcase
        end else begin
            regReadData <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    // entry: the one clock that loads the vector and pushes
    sequence s_entry;
        entryState == ENTER;
    endsequence

    // wait step: the machine has held one instruction cycle and meets Q4
    sequence s_wait_step;
        entryState == WAIT && phase == MIC_PHASE_Q4;
    endsequence

    // no disable here: the check must see the first clock after release
    a_reset_clears_global: assert property (@(posedge clk)
        $fell(reset) |-> !coreCtrl[MIC_BIT_GLOBAL_EN])
        else $error("global enable not clear after reset");

    a_global_gates_req: assert property (@(posedge clk) disable iff (reset)
        !coreCtrl[MIC_BIT_GLOBAL_EN] |=> !irqRequest)
        else $error("request without global enable");

    a_return_sets_global: assert property (@(posedge clk) disable iff (reset)
        returnFromIrq |=> coreCtrl[MIC_BIT_GLOBAL_EN])
        else $error("return did not set global enable");

    a_entry_vectors: assert property (@(posedge clk) disable iff (reset)
        s_entry |=> vectorLoad && stackPush && vectorAddress == PC_WIDTH'(MIC_VECTOR))
        else $error("entry did not vector");

    a_entry_clears_global: assert property (@(posedge clk) disable iff (reset)
        (s_entry and !returnFromIrq) |=> !coreCtrl[MIC_BIT_GLOBAL_EN])
        else $error("entry left global enable set");

    a_timer_flag_set: assert property (@(posedge clk) disable iff (reset)
        timerRoll |=> coreCtrl[MIC_BIT_TIMER_FLAG])
        else $error("rollover missed");

    a_periph_flag_set: assert property (@(posedge clk) disable iff (reset)
        periphEvent != 8'h00 |=> (periphFlags & $past(periphEvent)) == $past(periphEvent))
        else $error("peripheral flag missed");

    a_pin_flag_window: assert property (@(posedge clk) disable iff (reset)
        extEdge |-> ##[1:3] coreCtrl[MIC_BIT_PIN_FLAG])
        else $error("pin flag not set");

    a_request_to_entry: assert property (@(posedge clk) disable iff (reset)
        irqRequest && !sleeping && entryState == IDLE && phase == MIC_PHASE_Q4
        |-> ##[1:9] s_entry)
        else $error("entry too late");

    a_wake_ignores_global: assert property (@(posedge clk) disable iff (reset)
        sleeping && anyEnabled |=> wakeUp)
        else $error("no wake");

    a_wait_to_entry: assert property (@(posedge clk) disable iff (reset)
        s_wait_step |=> s_entry)
        else $error("wait step did not enter");

    a_entry_pushes_return: assert property (@(posedge clk) disable iff (reset)
        s_entry |=> pushAddress == $past(returnAddress))
        else $error("wrong return address pushed");

    a_no_stray_vector: assert property (@(posedge clk) disable iff (reset)
        entryState != ENTER |=> !vectorLoad && !stackPush)
        else $error("vector without entry");

    a_clear_blocks_req: assert property (@(posedge clk) disable iff (reset)
        clearGlobalEnable |=> !irqRequest)
        else $error("request beside a global enable clear");

    a_change_flag_set: assert property (@(posedge clk) disable iff (reset)
        portChange && !(portRead && phase == MIC_PHASE_Q2) |=> coreCtrl[MIC_BIT_CHANGE_FLAG])
        else $error("port change missed");

    a_pin_flag_phase: assert property (@(posedge clk) disable iff (reset)
        $rose(coreCtrl[MIC_BIT_PIN_FLAG]) && !$past(regWrite)
        |-> phase == MIC_PHASE_Q1 || phase == MIC_PHASE_Q2)
        else $error("pin flag set outside its window");

    a_wake_only_enabled: assert property (@(posedge clk) disable iff (reset)
        !anyEnabled |=> !wakeUp)
        else $error("wake without an enabled source");

endmodule : mic_interrupt_controller

// File: mic_interrupt_controller_tb.sv
// testbench: register access, event flags, vectored entry and sleep wake-up
`timescale 1ns/100ps
module mic_interrupt_controller_tb;
    import mic_pkg::*;
    logic clk, reset, regWrite, regRead, extPin, portRead, sleeping;
    logic clearGlobalEnable, doReturn, irqRequest, vectorLoad, stackPush, wakeUp, returnFromIrq;
    logic [3:0] regAddr;
    logic [7:0] regWriteData, regReadData, timer0Count, periphEvent, rd, expv;
    logic [5:0] portPins;
    logic [12:0] pc, vectorAddress, pushAddress;
    logic [1:0] phase;
    int entries, failCount, checks, cycles, n;
    mic_interrupt_controller u_mic_interrupt_controller (.clk(clk), .reset(reset),
        .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
        .regRead(regRead), .regReadData(regReadData), .extPin(extPin), .portPins(portPins),
        .portRead(portRead), .timer0Count(timer0Count), .periphEvent(periphEvent),
        .returnFromIrq(returnFromIrq), .clearGlobalEnable(clearGlobalEnable),
        .sleeping(sleeping), .returnAddress(pc), .irqRequest(irqRequest),
        .vectorLoad(vectorLoad), .vectorAddress(vectorAddress), .stackPush(stackPush),
        .pushAddress(pushAddress), .wakeUp(wakeUp), .phase(phase));
    mic_core_model u_mic_core_model (.clk(clk), .reset(reset), .vectorLoad(vectorLoad),
        .vectorAddress(vectorAddress), .stackPush(stackPush), .pushAddress(pushAddress),
        .doReturn(doReturn), .returnFromIrq(returnFromIrq), .pc(pc), .entries(entries));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            failCount++;
            printVerdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic printVerdict;
        $display("checks %0d mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : printVerdict
    task automatic check(input logic [12:0] seen, input logic [12:0] want);
        checks++;
        if (seen !== want) begin
            failCount++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe, so sample it there
    task automatic expectReg(input logic [3:0] a, input logic [7:0] want);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 rd = regReadData;
        check({5'h00, rd}, {5'h00, want});
    endtask : expectReg
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic pulse(input logic [7:0] ev);
        @(posedge clk);
        periphEvent <= ev;
        @(posedge clk);
        periphEvent <= 8'h00;
    endtask : pulse
    task automatic retire;
        @(posedge clk);
        doReturn <= 1'b1;
        @(posedge clk);
        doReturn <= 1'b0;
        tick(2);
    endtask : retire
    task automatic waitVector;
        for (n = 0; n < 40 && vectorLoad !== 1'b1; n++) tick(1);
    endtask : waitVector
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset, regWrite, regRead, extPin, portRead, sleeping} = 6'h20;
        {clearGlobalEnable, doReturn, regAddr, regWriteData, portPins} = '0;
        {timer0Count, periphEvent, failCount, checks, cycles} = '0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        // reset values, readback and an unmapped place
        expectReg(MIC_ADDR_CORE_CTRL, MIC_RESET_REG);
        expectReg(MIC_ADDR_PERIPH_EN, 8'h00);
        expectReg(MIC_ADDR_PERIPH_FLAGS, 8'h00);
        expectReg(4'h9, 8'h00);
        wr(MIC_ADDR_PERIPH_EN, 8'ha5);
        expectReg(MIC_ADDR_PERIPH_EN, 8'ha5);
        wr(MIC_ADDR_PERIPH_EN, 8'h00);
        // every peripheral source latches with all enables clear
        expv = 8'h00;
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i);
            expv = expv | (8'h01 << i);
            expectReg(MIC_ADDR_PERIPH_FLAGS, expv);
        end
        wr(MIC_ADDR_PERIPH_EN, 8'hff);
        wr(MIC_ADDR_CORE_CTRL, 8'h40);
        tick(2);
        check({12'h000, irqRequest}, 13'h0000);
        wr(MIC_ADDR_CORE_CTRL, 8'h00);
        wr(MIC_ADDR_PERIPH_FLAGS, 8'h00);
        // timer rollover
        @(posedge clk);
        timer0Count <= MIC_TIMER_MAX;
        @(posedge clk);
        timer0Count <= MIC_TIMER_ZERO;
        expectReg(MIC_ADDR_CORE_CTRL, 8'h04);
        wr(MIC_ADDR_CORE_CTRL, 8'h00);
        // pin edges: falling selected first, then rising
        extPin <= 1'b1;
        tick(12);
        expectReg(MIC_ADDR_CORE_CTRL, 8'h00);
        @(posedge clk);
        extPin <= 1'b0;
        tick(12);
        expectReg(MIC_ADDR_CORE_CTRL, 8'h02);
        wr(MIC_ADDR_CORE_CTRL, 8'h00);
        wr(MIC_ADDR_EDGE_SEL, 8'h01);
        extPin <= 1'b1;
        tick(12);
        expectReg(MIC_ADDR_CORE_CTRL, 8'h02);
        wr(MIC_ADDR_CORE_CTRL, 8'h00);
        // port change on an unselected, then a selected pin
        wr(MIC_ADDR_PIN_SELECT, 8'h01);
        portRead <= 1'b1;
        tick(4);
        @(posedge clk);
        portRead <= 1'b0;
        portPins <= 6'h02;
        tick(12);
        expectReg(MIC_ADDR_CORE_CTRL, 8'h00);
        @(posedge clk);
        portPins <= 6'h03;
        tick(12);
        expectReg(MIC_ADDR_CORE_CTRL, 8'h01);
        portRead <= 1'b1;
        tick(4);
        @(posedge clk);
        portRead <= 1'b0;
        wr(MIC_ADDR_CORE_CTRL, 8'h00);
        // peripheral request through both enables reaches the vector
        wr(MIC_ADDR_PERIPH_EN, 8'h01);
        pulse(8'h01);
        wr(MIC_ADDR_CORE_CTRL, 8'hc0);
        waitVector();
        check({12'h000, vectorLoad}, 13'h0001);
        check({12'h000, stackPush}, 13'h0001);
        check(vectorAddress, MIC_VECTOR);
        check(pushAddress, 13'h0123);
        tick(2);
        check(pc, MIC_VECTOR);
        expectReg(MIC_ADDR_CORE_CTRL, 8'h40);
        expectReg(MIC_ADDR_PERIPH_FLAGS, 8'h01);
        check({12'h000, irqRequest}, 13'h0000);
        wr(MIC_ADDR_PERIPH_FLAGS, 8'h00);
        retire();
        expectReg(MIC_ADDR_CORE_CTRL, 8'hc0);
        check(pc, 13'h0123);
        // an event beside a global-enable clear waits for the return
        @(posedge clk);
        periphEvent <= 8'h01;
        clearGlobalEnable <= 1'b1;
        @(posedge clk);
        periphEvent <= 8'h00;
        clearGlobalEnable <= 1'b0;
        tick(30);
        check(13'(entries), 13'd1);
        expectReg(MIC_ADDR_PERIPH_FLAGS, 8'h01);
        retire();
        waitVector();
        tick(2);
        check(13'(entries), 13'd2);
        wr(MIC_ADDR_PERIPH_FLAGS, 8'h00);
        retire();
        // sleep: enabled sources wake the core with the global enable clear
        wr(MIC_ADDR_CORE_CTRL, 8'h50);
        sleeping <= 1'b1;
        pulse(8'h01);
        tick(4);
        check({12'h000, wakeUp}, 13'h0001);
        wr(MIC_ADDR_PERIPH_FLAGS, 8'h00);
        tick(3);
        check({12'h000, wakeUp}, 13'h0000);
        @(posedge clk);
        extPin <= 1'b0;
        tick(12);
        @(posedge clk);
        extPin <= 1'b1;
        tick(12);
        check({12'h000, wakeUp}, 13'h0001);
        check(13'(entries), 13'd2);
        wr(MIC_ADDR_CORE_CTRL, 8'h00);
        sleeping <= 1'b0;
        // a second reset in mid-run drops the global enable
        wr(MIC_ADDR_CORE_CTRL, 8'hc0);
        reset <= 1'b1;
        tick(3);
        @(posedge clk);
        reset <= 1'b0;
        expectReg(MIC_ADDR_CORE_CTRL, 8'h00);
        check({11'h000, phase}, 13'h0002);
        printVerdict();
    end
endmodule : mic_interrupt_controller_tb

// File: mic_pkg.sv
// package: register map, bit positions and timing counts of the interrupt controller
package mic_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] MIC_ADDR_CORE_CTRL = 4'h0;  // core_interrupt_control
    localparam logic [3:0] MIC_ADDR_PERIPH_EN = 4'h1;  // peripheral_interrupt_enables
    localparam logic [3:0] MIC_ADDR_PERIPH_FLAGS = 4'h2;  // peripheral_interrupt_flags
    localparam logic [3:0] MIC_ADDR_EDGE_SEL = 4'h3;  // ext_edge_select in bit 0
    localparam logic [3:0] MIC_ADDR_PIN_SELECT = 4'h4;  // port_change_pin_select
    localparam logic [3:0] MIC_ADDR_STATUS = 4'h5;  // live status, read only
    // core_interrupt_control bit positions
    localparam int MIC_BIT_GLOBAL_EN = 7;
    localparam int MIC_BIT_PERIPH_EN = 6;
    localparam int MIC_BIT_TIMER_EN = 5;
    localparam int MIC_BIT_PIN_EN = 4;
    localparam int MIC_BIT_CHANGE_EN = 3;
    localparam int MIC_BIT_TIMER_FLAG = 2;
    localparam int MIC_BIT_PIN_FLAG = 1;
    localparam int MIC_BIT_CHANGE_FLAG = 0;
    // reset value and timer rollover bounds
    localparam logic [7:0] MIC_RESET_REG = 8'h00;
    localparam logic [7:0] MIC_TIMER_MAX = 8'hff;
    localparam logic [7:0] MIC_TIMER_ZERO = 8'h00;
    // interrupt vector loaded into the program counter
    localparam logic [12:0] MIC_VECTOR = 13'h0004;
    // clock subdivision: four phases per instruction cycle
    localparam int MIC_PHASES = 4;
    localparam logic [1:0] MIC_PHASE_Q1 = 2'h0;
    localparam logic [1:0] MIC_PHASE_Q2 = 2'h1;
    localparam logic [1:0] MIC_PHASE_Q4 = 2'h3;
    // entry: one wait cycle then vector; total latency three or four cycles
    localparam int MIC_ENTRY_CYCLES = 2;
endpackage : mic_pkg
